/* File: hw/sbs_core.sv */
// Serial rate generator and transfer status flags
// Operation
// - As master the serial clock is the bus clock divided by 2 to 2048, set by two 3-bit fields.
// - The divisor is (preselection + 1) times two to the power (selection + 1).
// - Status is readable at any time and writes to it change nothing.
// - Receive-complete in bit 7 sets when a received byte reaches the data buffer.
// - Receive-complete clears on a status read that saw it set, then a data read.
// - Transmit-empty in bit 5 is one while the transmit register is empty.
// - A status read seeing transmit-empty then a data write loads the byte and clears it.
// - A data write without that preceding status read is ignored.
// - Mode-fault in bit 4 sets when slave select falls on a master with detection on.
// - Mode-fault clears on a status read that saw it set, then a control one write.
// - A mode fault drops master select, disables outputs, aborts, and may interrupt.
// - Unserviced receive-complete keeps the first byte and drops later bytes.
`timescale 1ns/1ps
`include "sbs_defs.svh"
module sbs_core
	import sbs_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Register port
	input  wire sbs_bus_s   bus,
	output logic [7:0]      rdata,
	// Serial pins
	input  wire logic       sclk_in,
	output logic            sclk_out,
	output logic            sclk_oe_n,
	input  wire logic       ss_in_n,
	// Shift engine side
	input  wire logic       rx_done,
	input  wire logic [7:0] rx_byte,
	output logic [7:0]      tx_byte,
	output logic            tx_load,
	output logic            xfer_abort,
	// Interrupt
	output logic            irq
);
	// ==========================================================
	// Registers and synchronisers
	logic [7:0]  control_one, control_two, rate, irq_status, irq_mask, rx_buf;
	logic        rx_complete_flag, tx_empty_flag, mode_fault_flag;
	logic        armed_rx, armed_tx, armed_mf;
	logic [1:0]  ss_sync, sck_sync;
	logic        sck_prev;
	logic [10:0] div_cnt;
	logic [3:0]  edge_cnt;
	sbs_state_e  state;
	logic        master_select, mode_fault_detect_en, serial_irq_enable;
	logic        wr_ctl1, wr_data, rd_data, rd_stat, fault_evt, ss_prev;
	logic [11:0] divisor;
	logic [10:0] half_div;
	logic        sck_rise;

	assign master_select        = control_one[`SBS_BIT_MASTER];
	assign serial_irq_enable    = control_one[`SBS_BIT_IRQ_EN];
	assign mode_fault_detect_en = control_two[`SBS_BIT_FAULT_DET];
	assign wr_ctl1 = bus.wr && bus.addr == `SBS_OFS_CONTROL_ONE;
	assign wr_data = bus.wr && bus.addr == `SBS_OFS_DATA;
	assign rd_data = bus.rd && bus.addr == `SBS_OFS_DATA;
	assign rd_stat = bus.rd && bus.addr == `SBS_OFS_STATUS;
	// Falling slave select seen on the second synchroniser stage only
	assign fault_evt = master_select && mode_fault_detect_en && ss_prev && !ss_sync[1];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ss_sync  <= 2'h3;
			sck_sync <= 2'h0;
			ss_prev  <= 1'b1;
			sck_prev <= 1'b0;
		end else begin
			ss_sync  <= {ss_sync[0], ss_in_n};
			sck_sync <= {sck_sync[0], sclk_in};
			ss_prev  <= ss_sync[1];
			sck_prev <= sck_sync[1];
		end
	end
	// Slave edge seen on the link clock, used only by a cover
	assign sck_rise = sck_sync[1] && !sck_prev;

	// ==========================================================
	// Control registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			control_one <= `SBS_CONTROL_ONE_RST;
			control_two <= `SBS_CONTROL_TWO_RST;
			rate        <= `SBS_RATE_RST;
			irq_mask    <= `SBS_IRQ_MASK_RST;
		end else begin
			if (fault_evt)
				control_one[`SBS_BIT_MASTER] <= 1'b0;
			else if (wr_ctl1)
				control_one <= bus.wdata;
			if (bus.wr && bus.addr == `SBS_OFS_CONTROL_TWO)
				control_two <= bus.wdata;
			if (bus.wr && bus.addr == `SBS_OFS_RATE)
				rate <= {1'b0, bus.wdata[6:4], 1'b0, bus.wdata[2:0]};
			if (bus.wr && bus.addr == `SBS_OFS_IRQ_MASK)
				irq_mask <= bus.wdata;
		end
	end

	// ==========================================================
	// Status flags; the set wins over a clear, except transmit-empty where a data load clear wins over the set
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_complete_flag <= 1'b0;
			tx_empty_flag    <= 1'b1;
			mode_fault_flag  <= 1'b0;
			armed_rx <= 1'b0;
			armed_tx <= 1'b0;
			armed_mf <= 1'b0;
			rx_buf   <= 8'h00;
			tx_byte  <= 8'h00;
			tx_load  <= 1'b0;
		end else begin
			tx_load <= 1'b0;
			if (rd_stat) begin
				armed_rx <= rx_complete_flag;
				armed_tx <= tx_empty_flag;
				armed_mf <= mode_fault_flag;
			end
			if (rx_done && !rx_complete_flag) begin
				rx_buf           <= rx_byte;
				rx_complete_flag <= 1'b1;
			end else if (rd_data && armed_rx) begin
				rx_complete_flag <= 1'b0;
				armed_rx         <= 1'b0;
			end
			if (wr_data && armed_tx && tx_empty_flag) begin
				tx_byte       <= bus.wdata;
				tx_load       <= 1'b1;
				tx_empty_flag <= 1'b0;
				armed_tx      <= 1'b0;
			end else if (rx_done && !tx_empty_flag) begin
				tx_empty_flag <= 1'b1;
			end
			if (fault_evt)
				mode_fault_flag <= 1'b1;
			else if (wr_ctl1 && armed_mf) begin
				mode_fault_flag <= 1'b0;
				armed_mf        <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Interrupt status, write one to clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_status <= 8'h00;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (bus.wr && bus.addr == `SBS_OFS_IRQ_STATUS && bus.wdata[i])
					irq_status[i] <= 1'b0;
			end
			if (rx_done && !rx_complete_flag)
				irq_status[`SBS_BIT_RX_COMPLETE] <= 1'b1;
			if (wr_data && armed_tx && tx_empty_flag)
				irq_status[`SBS_BIT_TX_EMPTY] <= 1'b1;
			if (fault_evt)
				irq_status[`SBS_BIT_MODE_FAULT] <= 1'b1;
		end
	end
	assign irq = serial_irq_enable && |(irq_status & irq_mask);

	// ==========================================================
	// Rate generator
	// Shift amount kept four bits wide so a selection of seven shifts by eight, reaching 2048 at preselection seven
	assign divisor  = 12'({9'h000, rate[6:4]} + 12'h001) << ({1'b0, rate[2:0]} + 4'h1);
	assign half_div = 11'(divisor >> 1);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state      <= SBS_IDLE;
			div_cnt    <= 11'h000;
			edge_cnt   <= 4'h0;
			sclk_out   <= 1'b0;
			xfer_abort <= 1'b0;
		end else begin
			xfer_abort <= 1'b0;
			if (fault_evt || !master_select) begin
				if (state != SBS_IDLE)
					xfer_abort <= fault_evt;
				state    <= SBS_IDLE;
				sclk_out <= 1'b0;
				edge_cnt <= 4'h0;
				div_cnt  <= 11'h000;
			end else begin
				unique case (state)
					SBS_IDLE: begin
						if (tx_load) begin
							state   <= SBS_HALF;
							div_cnt <= 11'h000;
						end
					end
					SBS_HALF: begin
						if (div_cnt == half_div - 11'h001) begin
							div_cnt  <= 11'h000;
							state    <= SBS_SHIFT;
							edge_cnt <= 4'h0;
						end else
							div_cnt <= div_cnt + 11'h001;
					end
					SBS_SHIFT: begin
						if (div_cnt == half_div - 11'h001) begin
							div_cnt  <= 11'h000;
							sclk_out <= !sclk_out;
							if (sclk_out)
								edge_cnt <= edge_cnt + 4'h1;
							if (sclk_out && edge_cnt == `SBS_BITS_PER_BYTE - 4'h1)
								state <= SBS_IDLE;
						end else
							div_cnt <= div_cnt + 11'h001;
					end
				endcase
			end
		end
	end
	// Outputs driven only as master; slave relies on a legal remote rate
	assign sclk_oe_n = !master_select;

	// ==========================================================
	// Read port
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			unique case (bus.addr)
				`SBS_OFS_CONTROL_ONE: rdata <= control_one;
				`SBS_OFS_CONTROL_TWO: rdata <= control_two;
				`SBS_OFS_RATE:        rdata <= rate;
				`SBS_OFS_STATUS:      rdata <= {rx_complete_flag, 1'b0, tx_empty_flag,
					mode_fault_flag, 4'h0};
				`SBS_OFS_DATA:        rdata <= rx_buf;
				`SBS_OFS_IRQ_STATUS:  rdata <= irq_status;
				`SBS_OFS_IRQ_MASK:    rdata <= irq_mask;
				default:              rdata <= 8'h00;
			endcase
		end else
			rdata <= 8'h00;
	end

	// ==========================================================
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	fault_drops_master_a: assert property (fault_evt |=> !master_select && mode_fault_flag)
		else $error("mode fault did not drop master");
	status_write_const_a: assert property (bus.wr && bus.addr == `SBS_OFS_STATUS && !rx_done
		&& !fault_evt |=> $stable(rx_complete_flag) && $stable(mode_fault_flag))
		else $error("status write changed flags");
	rx_set_a: assert property (rx_done && !rx_complete_flag |=> rx_complete_flag
		&& rx_buf == $past(rx_byte))
		else $error("receive flag not set");
	rx_keep_first_a: assert property (rx_complete_flag && rx_done |=> $stable(rx_buf))
		else $error("later byte overwrote buffer");
	rx_clear_a: assert property (rx_complete_flag && !armed_rx && !rx_done
		|=> rx_complete_flag)
		else $error("receive flag cleared without sequence");
	tx_ignore_a: assert property (wr_data && !armed_tx |=> !tx_load)
		else $error("unarmed data write accepted");
	tx_load_a: assert property (wr_data && armed_tx && tx_empty_flag
		|=> tx_load && !tx_empty_flag && tx_byte == $past(bus.wdata))
		else $error("armed data write not loaded");
	mf_hold_a: assert property (mode_fault_flag && !armed_mf |=> mode_fault_flag)
		else $error("mode fault cleared without sequence");
	reset_flags_a: assert property ($rose(rst_n) |-> tx_empty_flag && !rx_complete_flag)
		else $error("flags wrong after reset");
	rate_half_a: assert property (state == SBS_SHIFT && div_cnt == half_div - 11'h001
		&& master_select && !fault_evt
		|=> sclk_out != $past(sclk_out))
		else $error("serial clock did not toggle");

	// ==========================================================
	// Divisor range and rate counter bounds
	div_range_a: assert property (divisor >= 12'h002 && divisor <= 12'h800)
		else $error("divisor out of range");
	div_count_a: assert property (state != SBS_IDLE |-> div_cnt < half_div)
		else $error("rate counter overran half period");
	idle_clock_low_a: assert property (state == SBS_IDLE && master_select && !fault_evt
		&& !tx_load |=> !sclk_out)
		else $error("serial clock moved while idle");

	// ==========================================================
	// Status read path
	status_read_a: assert property (rd_stat |=> rdata == {$past(rx_complete_flag), 1'b0,
		$past(tx_empty_flag), $past(mode_fault_flag), 4'h0})
		else $error("status read value wrong");
	tx_empty_read_a: assert property (rd_stat && tx_empty_flag |=> rdata[5])
		else $error("transmit empty not shown");
	rdata_idle_a: assert property (!bus.rd |=> rdata == 8'h00)
		else $error("read data without a read");

	// ==========================================================
	// Flag clear sequences and mode fault set
	rx_clear_seq_a: assert property (rd_data && armed_rx && !rx_done
		|=> !rx_complete_flag)
		else $error("receive flag not cleared");
	mf_clear_a: assert property (wr_ctl1 && armed_mf && !fault_evt
		|=> !mode_fault_flag)
		else $error("mode fault not cleared");
	mf_set_a: assert property (fault_evt |=> mode_fault_flag)
		else $error("mode fault flag not set");

	// ==========================================================
	// Mode fault consequences
	abort_on_fault_a: assert property (fault_evt && state != SBS_IDLE
		|=> xfer_abort)
		else $error("transfer not aborted");
	fault_idle_a: assert property (fault_evt |=> state == SBS_IDLE && !sclk_out
		&& sclk_oe_n)
		else $error("fault did not force idle");
	fault_irq_a: assert property (fault_evt && serial_irq_enable
		&& irq_mask[`SBS_BIT_MODE_FAULT] |=> irq)
		else $error("fault did not raise interrupt");
	slave_quiet_a: assert property (!master_select |=> state == SBS_IDLE
		&& !sclk_out)
		else $error("slave drove the serial clock");

	// ==========================================================
	// Scenario covers
	fault_c: cover property (fault_evt);
	load_c: cover property (tx_load ##[1:300] state == SBS_IDLE);
	rx_c: cover property (rx_done ##[1:20] rd_data);
	mf_clear_c: cover property (wr_ctl1 && armed_mf);
	slave_edge_c: cover property (sck_rise && !master_select);
endmodule : sbs_core

/* File: hw/sbs_defs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH
`define SBS_OFS_CONTROL_ONE   4'h0
`define SBS_OFS_CONTROL_TWO   4'h1
`define SBS_OFS_RATE          4'h2
`define SBS_OFS_STATUS        4'h3
`define SBS_OFS_DATA          4'h5
`define SBS_OFS_IRQ_STATUS    4'h6
`define SBS_OFS_IRQ_MASK      4'h7
`define SBS_BIT_RX_COMPLETE   7
`define SBS_BIT_TX_EMPTY      5
`define SBS_BIT_MODE_FAULT    4
`define SBS_BIT_IRQ_EN        7
`define SBS_BIT_ENABLE        6
`define SBS_BIT_MASTER        4
`define SBS_BIT_FAULT_DET     4
`define SBS_CONTROL_ONE_RST   8'h04
`define SBS_CONTROL_TWO_RST   8'h00
`define SBS_RATE_RST          8'h00
`define SBS_IRQ_MASK_RST      8'h00
`define SBS_BITS_PER_BYTE     4'h8
`endif

/* File: hw/sbs_pkg.sv */
// Types shared by the baud and status block
package sbs_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} sbs_bus_s;
	typedef enum logic [2:0] {
		SBS_IDLE = 3'b001,
		SBS_HALF = 3'b010,
		SBS_SHIFT = 3'b100
	} sbs_state_e;
endpackage : sbs_pkg

/* File: tb/sbs_peer.sv */
// Remote master model that drives slave select and the serial clock
`timescale 1ns/1ps
module sbs_peer (
	// Frame request from the bench
	input  wire logic go,
	// Serial pins towards the device
	output logic      sclk,
	output logic      ss_n
);
	// =========================================
	// Frame generator
	initial begin
		sclk = 1'b0;
		ss_n = 1'b1;
		forever begin
			@(posedge go);
			ss_n = 1'b0;
			// 160 ns period, far below half the bus rate
			repeat (16) #80 sclk = ~sclk;
			// Clock stands still at its idle level between frames
			#80 ss_n = 1'b1;
		end
	end
endmodule : sbs_peer

/* File: tb/test_sbs_core.sv */
// Register level testbench for the rate generator and status flags
`timescale 1ns/1ps
`include "sbs_defs.svh"
module test_sbs_core;
	import sbs_pkg::*;
	logic       clk, rst_n, rx_done, go;
	logic       sclk_in, sclk_out, sclk_oe_n, ss_in_n, tx_load, xfer_abort, irq;
	logic [7:0] rx_byte, tx_byte, rdata, d;
	sbs_bus_s   bus;
	int         errors, n_checks, n, k;

	sbs_core dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
		.ss_in_n(ss_in_n), .rx_done(rx_done), .rx_byte(rx_byte), .tx_byte(tx_byte),
		.tx_load(tx_load), .xfer_abort(xfer_abort), .irq(irq));
	sbs_peer peer (.go(go), .sclk(sclk_in), .ss_n(ss_in_n));

	// =========================================
	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		errors++;
		end_of_test();
	end

	// =========================================
	// Bus access and checking
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk) bus <= '0;
		#1;
	endtask : wr
	task rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk) bus <= '0;
		#1 v = rdata;
	endtask : rd
	task rxd(input logic [7:0] b);
		@(posedge clk) begin
			rx_done <= 1'b1;
			rx_byte <= b;
		end
		@(posedge clk) rx_done <= 1'b0;
	endtask : rxd
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Bus clock cycles between two rising serial clock edges
	task period(output int p);
		p = 0;
		k = 0;
		while (sclk_out !== 1'b1 && k < 5000) begin @(posedge clk); #1 k++; end
		while (sclk_out === 1'b1 && p < 5000) begin @(posedge clk); #1 p++; end
		while (sclk_out !== 1'b1 && p < 5000) begin @(posedge clk); #1 p++; end
	endtask : period
	task end_of_test;
		if (errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test

	// =========================================
	// Test sequence
	initial begin
		bus = '0; rx_done = 1'b0; rx_byte = 8'h00; rst_n = 1'b0; go = 1'b0;
		errors = 0; n_checks = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		wr(`SBS_OFS_DATA, 8'h11); chk("tx_load", 8'h00, {7'h00, tx_load});
		rd(`SBS_OFS_STATUS, d); chk("status", 8'h20, d);
		rd(4'hF, d); chk("unmapped", 8'h00, d);
		wr(`SBS_OFS_STATUS, 8'hFF);
		rd(`SBS_OFS_STATUS, d); chk("status", 8'h20, d);
		wr(`SBS_OFS_CONTROL_ONE, 8'h50);
		wr(`SBS_OFS_RATE, 8'h00);
		rd(`SBS_OFS_STATUS, d);
		wr(`SBS_OFS_DATA, 8'hA5); chk("tx_load", 8'h01, {7'h00, tx_load});
		chk("tx_byte", 8'hA5, tx_byte);
		chk("sclk_oe_n", 8'h00, {7'h00, sclk_oe_n});
		period(n); chk("divisor", 8'h02, n[7:0]);
		rd(`SBS_OFS_STATUS, d); chk("status", 8'h00, d);
		rxd(8'h3C);
		rxd(8'h55);
		rd(`SBS_OFS_STATUS, d); chk("status", 8'hA0, d);
		rd(`SBS_OFS_DATA, d); chk("data", 8'h3C, d);
		rd(`SBS_OFS_STATUS, d); chk("status", 8'h20, d);
		wr(`SBS_OFS_RATE, 8'h12);
		wr(`SBS_OFS_CONTROL_TWO, 8'h10);
		wr(`SBS_OFS_CONTROL_ONE, 8'hD0);
		wr(`SBS_OFS_IRQ_MASK, 8'h10);
		rd(`SBS_OFS_STATUS, d);
		wr(`SBS_OFS_DATA, 8'h5A);
		period(n); chk("divisor", 8'h10, n[7:0]);
		go <= 1'b1;
		k = 0;
		while (xfer_abort !== 1'b1 && k < 20) begin @(posedge clk); #1 k++; end
		chk("xfer_abort", 8'h01, {7'h00, xfer_abort});
		chk("irq", 8'h01, {7'h00, irq});
		chk("sclk_oe_n", 8'h01, {7'h00, sclk_oe_n});
		rd(`SBS_OFS_CONTROL_ONE, d); chk("control_one", 8'hC0, d);
		rd(`SBS_OFS_STATUS, d); chk("fault", 8'h10, d & 8'h10);
		wr(`SBS_OFS_CONTROL_ONE, 8'hC0);
		rd(`SBS_OFS_STATUS, d); chk("fault", 8'h00, d & 8'h10);
		wr(`SBS_OFS_IRQ_MASK, 8'h00); chk("irq", 8'h00, {7'h00, irq});
		wr(`SBS_OFS_IRQ_MASK, 8'h10); chk("irq", 8'h01, {7'h00, irq});
		wr(`SBS_OFS_IRQ_STATUS, 8'h10); chk("irq", 8'h00, {7'h00, irq});
		end_of_test();
	end
endmodule : test_sbs_core
